// >>> design/crs_pkg.sv
// package for the chip reset sequencer: timing counts, config word width and reset value, carrier types
// assumes a single reference clock drives the sequencer
package crs_pkg;

   // ==========================================================
   // timing
   // ==========================================================
   localparam int unsigned STRETCH_CYCLES = 1024;
   localparam int unsigned QUIET_CYCLES   = 16;
   localparam int unsigned CNT_W          = 11;
   localparam int unsigned QUIET_W        = 5;

   // ==========================================================
   // configuration word
   // ==========================================================
   localparam int unsigned CFG_W = 16;
   localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;

   // ==========================================================
   // carrier types
   // ==========================================================
   // internal reset carriers: hard and soft request in (active high), hard and soft reset out (active low at the ports)
   typedef struct packed {
      logic hardReq;
      logic softReq;
   } crs_int_req_t;

   typedef struct packed {
      logic hardRst;
      logic softRst;
   } crs_int_rst_t;

   typedef enum logic [1:0] {
      CRS_POR,
      CRS_HOLD,
      CRS_QUIET,
      CRS_IDLE
   } crs_state_t;

endpackage

// >>> design/crs_chip_reset_sequencer.sv
// chip reset sequencer: power-on, hard and soft reset combining and stretching
// pins are asynchronous to core_clk and pass two-stage synchronisers; the pad ring resolves open-drain wires
//
// Contract
// - reset pins open-drain; hard, soft bidirectional
// - output enable follows reset, level ground
// - counters hold detected resets 1024 cycles
// - power-on low forces hard and soft
// - config word captured at power-on release
// - after power-on, hold resets 1024 cycles
// - ignore external resets 16 cycles after release
// - external hard drives all four resets
// - internal hard drives both pins; soft drives soft
// - hard sources: pins, debug, watchdog/checkstop
// - external soft drives soft resets only
// - soft sources: pins, control bit, debug
// - long external hard still stretches 1024 only
// - long external soft still stretches 1024 only
// - soft-reset bit zero starts soft reset
// - store config word, distribute to users
// - test-port logic not reset here
`timescale 1ns/100ps
`default_nettype none

module crs_chip_reset_sequencer #(
   parameter int unsigned STRETCH = crs_pkg::STRETCH_CYCLES,
   parameter int unsigned QUIET   = crs_pkg::QUIET_CYCLES,
   parameter int unsigned CFG_W   = crs_pkg::CFG_W
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic                 powerOnReset_n,
   input  wire logic                 hardResetIn_n,
   output logic                      hardResetOe,
   output logic                      hardResetOut,
   input  wire logic                 softResetIn_n,
   output logic                      softResetOe,
   output logic                      softResetOut,
   input  wire crs_pkg::crs_int_req_t intReq,
   input  wire logic                 softResetBit_n,
   input  wire logic [CFG_W-1:0]     cfgPins,
   output logic [CFG_W-1:0]          resetConfig,
   output crs_pkg::crs_int_rst_t     intRst_n
);

   // ==========================================================
   // input synchronisers
   // ==========================================================
   // two stages per pin; only the second stage feeds detection, so a pin
   // that moves close to an edge costs one cycle, never a split decision
   localparam int unsigned PIN_N = 3;
   logic [PIN_N-1:0] pinLow;
   logic [PIN_N-1:0] syncA;
   logic [PIN_N-1:0] syncB;
   assign pinLow = {~powerOnReset_n, ~hardResetIn_n, ~softResetIn_n};

   genvar gi;
   generate
      for (gi = 0; gi < PIN_N; gi++) begin : g_sync
         always_ff @(posedge core_clk) begin
            if (rst) begin
               syncA[gi] <= 1'b0;
               syncB[gi] <= 1'b0;
            end else begin
               syncA[gi] <= pinLow[gi];
               syncB[gi] <= syncA[gi];
            end
         end
      end
   endgenerate

   logic porAct;
   logic extHard;
   logic extSoft;
   assign porAct  = syncB[2];
   assign extHard = syncB[1];
   assign extSoft = syncB[0];

   // ==========================================================
   // sequencer state
   // ==========================================================
   crs_pkg::crs_state_t state;
   crs_pkg::crs_state_t next_state;
   logic [crs_pkg::CNT_W-1:0]   cnt;
   logic [crs_pkg::QUIET_W-1:0] quietCnt;
   logic                        hardHold;
   logic                        softHold;
   logic                        ownHard;
   logic                        ownSoft;

   // our own pin drive loops back on the pins; pins seen low while we
   // drive them are not new requests, hence the masking below
   logic hardStart;
   logic softStart;
   logic extOk;
   assign extOk     = (state == crs_pkg::CRS_IDLE);
   assign hardStart = intReq.hardReq | (extOk & extHard);
   assign softStart = intReq.softReq | ~softResetBit_n | (extOk & extSoft);

   // an internal hard request that arrives during a soft-only hold widens it to a
   // hard hold and restarts the count; otherwise that hard source would
   // be dropped for good, since internal requests are levels only while
   // the requester chooses to hold them
   logic upgrade;
   assign upgrade = (state == crs_pkg::CRS_HOLD) & ~hardHold & intReq.hardReq;

   logic cntDone;
   assign cntDone = (cnt == crs_pkg::CNT_W'(STRETCH - 1));

   always_comb begin
      next_state = state;
      case (state)
         crs_pkg::CRS_POR: begin
            if (!porAct) begin
               next_state = crs_pkg::CRS_HOLD;
            end
         end
         crs_pkg::CRS_HOLD: begin
            if (porAct) begin
               next_state = crs_pkg::CRS_POR;
            end else if (cntDone && !upgrade) begin
               next_state = crs_pkg::CRS_QUIET;
            end
         end
         crs_pkg::CRS_QUIET: begin
            if (porAct) begin
               next_state = crs_pkg::CRS_POR;
            end else if (hardStart || softStart) begin
               next_state = crs_pkg::CRS_HOLD;
            end else if (quietCnt == crs_pkg::QUIET_W'(QUIET - 1)) begin
               next_state = crs_pkg::CRS_IDLE;
            end
         end
         default: begin
            if (porAct) begin
               next_state = crs_pkg::CRS_POR;
            end else if (hardStart || softStart) begin
               next_state = crs_pkg::CRS_HOLD;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= crs_pkg::CRS_POR;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // stretch counter
   // ==========================================================
   // counts exactly STRETCH cycles regardless of how long a pin stays low
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt <= '0;
      end else if (state != crs_pkg::CRS_HOLD) begin
         cnt <= '0;
      end else if (upgrade) begin
         cnt <= '0;
      end else if (!cntDone) begin
         cnt <= cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         quietCnt <= '0;
      end else if (state == crs_pkg::CRS_QUIET) begin
         quietCnt <= quietCnt + 1'b1;
      end else begin
         quietCnt <= '0;
      end
   end

   // which resets the current hold covers; hard implies soft
   // the flags are only loaded outside a hold or by an upgrade, so a pin that stays low
   // for longer than the hold cannot keep the flags up
   always_ff @(posedge core_clk) begin
      if (rst) begin
         hardHold <= 1'b1;
      end else if (porAct) begin
         hardHold <= 1'b1;
      end else if (state == crs_pkg::CRS_HOLD) begin
         if (upgrade) begin
            hardHold <= 1'b1;
         end else if (cntDone) begin
            hardHold <= 1'b0;
         end
      end else if (state != crs_pkg::CRS_POR) begin
         hardHold <= hardStart;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         softHold <= 1'b1;
      end else if (porAct) begin
         softHold <= 1'b1;
      end else if (state == crs_pkg::CRS_HOLD) begin
         if (upgrade) begin
            softHold <= 1'b1;
         end else if (cntDone) begin
            softHold <= 1'b0;
         end
      end else if (state != crs_pkg::CRS_POR) begin
         softHold <= hardStart | softStart;
      end
   end

   // ==========================================================
   // pin and internal reset drive
   // ==========================================================
   // driven level always ground; enable carries the reset, pull-up gives high
   assign ownHard = hardHold;
   assign ownSoft = softHold;
   // the pin enables and the internal resets leave from one register stage
   // each, so the pins and the internal resets move in the same cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         hardResetOe  <= 1'b1;
         hardResetOut <= 1'b0;
      end else begin
         hardResetOe  <= ownHard;
         hardResetOut <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         softResetOe  <= 1'b1;
         softResetOut <= 1'b0;
      end else begin
         softResetOe  <= ownSoft;
         softResetOut <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         intRst_n <= '0;
      end else begin
         intRst_n.hardRst <= ~ownHard;
         intRst_n.softRst <= ~ownSoft;
      end
   end

   // ==========================================================
   // reset configuration word
   // ==========================================================
   // sampled all through power-on, frozen at its release; test-port logic
   // has its own reset and is not touched here
   // no test-port reset is produced by this block at all
   always_ff @(posedge core_clk) begin
      if (rst) begin
         resetConfig <= CFG_W'(crs_pkg::CFG_RESET);
      end else if (state == crs_pkg::CRS_POR) begin
         resetConfig <= cfgPins;
      end
   end

endmodule

`default_nettype wire

// >>> tb/crs_assertions.sv
// checker on the reset sequencer ports
// bound to the sequencer below; counts follow its parameters
`timescale 1ns/100ps
`default_nettype none
module crs_assertions #(
   parameter int unsigned STRETCH = 20,
   parameter int unsigned CFG_W   = 16
) (
   input wire logic                  core_clk,
   input wire logic                  rst,
   input wire logic                  powerOnReset_n,
   input wire logic                  hardResetOe,
   input wire logic                  hardResetOut,
   input wire logic                  softResetOe,
   input wire logic                  softResetOut,
   input wire crs_pkg::crs_int_req_t intReq,
   input wire logic                  softResetBit_n,
   input wire logic [CFG_W-1:0]      resetConfig,
   input wire crs_pkg::crs_int_rst_t intRst_n
);
   // ==========================================
   // checks
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   gnd_a: assert property (!hardResetOut && !softResetOut) else $error("drive not low");
   hpair_a: assert property (hardResetOe |-> softResetOe) else $error("hard pin alone");
   ipair_a: assert property (!intRst_n.hardRst |-> !intRst_n.softRst) else $error("hard alone");
   hmatch_a: assert property (hardResetOe == !intRst_n.hardRst) else $error("pin vs internal");
   por_a: assert property (!powerOnReset_n [*5] |-> hardResetOe) else $error("por not forced");
   hreq_a: assert property ($rose(intReq.hardReq) && !hardResetOe |-> ##[1:6] hardResetOe)
      else $error("hard request lost");
   sbit_a: assert property ($fell(softResetBit_n) && !softResetOe |-> ##[1:6] softResetOe)
      else $error("soft bit lost");
   cfg_a: assert property (powerOnReset_n [*6] |-> $stable(resetConfig)) else $error("cfg moved");
   // run length of the hard pin drive once power-on is released
   int unsigned oeRun;
   always_ff @(posedge core_clk) begin
      if (rst || !powerOnReset_n || !hardResetOe) oeRun <= '0;
      else oeRun <= oeRun + 1;
   end
   hlen_a: assert property (oeRun <= STRETCH + 4) else $error("hard hold too long");
endmodule
bind crs_chip_reset_sequencer crs_assertions #(.STRETCH(STRETCH), .CFG_W(CFG_W)) chk (.*);
`default_nettype wire

// >>> tb/crs_board_model.sv
// board reset source: pull-ups plus a switch on each open-drain wire
// the bench closes the switches; the sequencer enables come from the design
`timescale 1ns/100ps
`default_nettype none
module crs_board_model (
   input wire logic pullHard,
   input wire logic pullSoft,
   input wire logic hardResetOe,
   input wire logic softResetOe,
   output logic     hardResetIn_n,
   output logic     softResetIn_n
);
   // ==========================================
   // wired-and: pull-up unless some party pulls low
   assign hardResetIn_n = !(pullHard || hardResetOe);
   assign softResetIn_n = !(pullSoft || softResetOe);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// bench for the reset sequencer with short counts
// board model closes the wires; bench drives on the falling edge
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam int S = 20;
   localparam int Q = 8;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic powerOnReset_n = 1'b0;
   logic [4:0] src = 5'h00;
   logic [15:0] cfgPins = 16'h0f0f;
   logic pullHard, pullSoft, hardResetIn_n, softResetIn_n, softResetBit_n;
   logic hardResetOe, softResetOe, hardResetOut, softResetOut;
   logic [15:0] resetConfig;
   crs_pkg::crs_int_req_t intReq;
   crs_pkg::crs_int_rst_t intRst_n;
   int n_errors = 0;
   int samples_checked = 0;
   int cnt[4];
   assign pullHard = src[0];
   assign pullSoft = src[1];
   assign intReq = {src[2], src[3]};
   assign softResetBit_n = !src[4];
   crs_board_model board (.*);
   crs_chip_reset_sequencer #(.STRETCH(S), .QUIET(Q)) uut (.*);
   // ==========================================
   // tasks
   initial forever #2.5 core_clk = ~core_clk;
   function automatic logic [3:0] act();
      return {hardResetOe, softResetOe, !intRst_n.hardRst, !intRst_n.softRst};
   endfunction
   task automatic complete_run();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   // a pulse counts as absent if nothing shows within 12 cycles
   task automatic measure();
      logic [3:0] a;
      cnt = '{default: 0};
      for (int k = 0; k < 4 * S; k++) begin
         a = act();
         if (a === 4'h0 && (k > 11 || cnt.sum() > 0))
            return;
         foreach (cnt[i]) cnt[i] += a[i];
         @(negedge core_clk);
      end
      n_errors++;
      complete_run();
   endtask
   task automatic run(input int kind, input int len, input logic [3:0] mask);
      repeat (Q + 4) @(negedge core_clk);
      fork
         begin
            src[kind] = 1'b1;
            repeat (len) @(negedge core_clk);
            src[kind] = 1'b0;
         end
         measure();
      join
      foreach (cnt[i]) cmp(16'(cnt[i]), mask[i] ? 16'(S) : 16'h0000);
   endtask
   task automatic t_power_on();
      repeat (20) @(negedge core_clk);
      cmp(16'(act()), 16'h000f);
      cfgPins = 16'h5a3c;
      repeat (5) @(negedge core_clk);
      powerOnReset_n = 1'b1;
      measure();
      cmp(16'(cnt[3] >= S && cnt[3] <= S + 4), 16'h0001);
      cfgPins = 16'h00ff;
      repeat (4) @(negedge core_clk);
      cmp(resetConfig, 16'h5a3c);
   endtask
   task automatic t_sources();
      run(0, 4, 4'hf);
      run(0, S + 5, 4'hf);
      run(1, S + 5, 4'h5);
      run(2, 4, 4'hf);
      run(3, 4, 4'h5);
      run(4, 4, 4'h5);
   endtask
   task automatic t_quiet();
      run(0, 4, 4'hf);
      fork
         begin
            src[1] = 1'b1;
            repeat (4) @(negedge core_clk);
            src[1] = 1'b0;
         end
         measure();
      join
      cmp(16'(cnt[2] + cnt[0]), 16'h0000);
   endtask
   // soft hold from an internal source, widened by a hard request mid-hold
   task automatic t_upgrade();
      repeat (Q + 4) @(negedge core_clk);
      fork
         begin
            src[3] = 1'b1;
            repeat (4) @(negedge core_clk);
            src[3] = 1'b0;
            repeat (6) @(negedge core_clk);
            src[2] = 1'b1;
            repeat (4) @(negedge core_clk);
            src[2] = 1'b0;
         end
         measure();
      join
      cmp(16'(cnt[3]), 16'(S));
      cmp(16'(cnt[2]), 16'(S + 10));
   endtask
   initial begin
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      t_power_on();
      t_sources();
      t_quiet();
      t_upgrade();
      complete_run();
   end
endmodule
`default_nettype wire
